// ---- hdl/ldrp_pkg.sv ----
// package for the lpc dma read request block: field codes and timing counts
// assumes both ends run on the one lpc clock
package ldrp_pkg;
    localparam logic [3:0] LDRP_START      = 4'h0;
    localparam logic [1:0] LDRP_CYC_DMA    = 2'h2;
    localparam logic [1:0] LDRP_DIR_READ   = 2'h0;
    localparam logic [1:0] LDRP_SIZE_8     = 2'h0;
    localparam logic [3:0] LDRP_SYNC_MORE  = 4'h9;
    localparam logic [3:0] LDRP_SYNC_DONE  = 4'h0;
    localparam logic [3:0] LDRP_SYNC_WAIT  = 4'h5;
    localparam logic [3:0] LDRP_TAR_HIGH   = 4'hf;
    localparam int         LDRP_TC_BIT     = 3;
    localparam int         LDRP_WAIT_NUM   = 3;
    localparam int         LDRP_HOLDOFF    = 8;
    localparam int         LDRP_SYNC_LIMIT = 16;
endpackage : ldrp_pkg

// ---- hdl/ldrp_if.sv ----
// interface joining peripheral and host ends of the lpc dma link
// assumes the testbench resolves the nibble bus from the two enables
`timescale 1ns/1ps
interface ldrp_if;
    logic       req_n;
    logic       frame_n;
    logic [3:0] host_ad;
    logic       host_ad_oe;
    logic [3:0] dev_ad;
    logic       dev_ad_oe;
    logic [3:0] ad;
    modport dev  (output req_n, input frame_n, input ad, output dev_ad, output dev_ad_oe);
    modport host (input req_n, output frame_n, input ad, output host_ad, output host_ad_oe);
endinterface : ldrp_if

// ---- hdl/ldrp_periph.sv ----
// peripheral end: serial dma request and 8-bit dma read data capture
// assumes link pins synchronous to clock_i; bus level resolved outside
//
// Operation
// - request opens with one low start bit
// - three channel bits follow, msb first
// - active bit high, then one deassert clock
// - new request waits for sync 0000 and the hold-off
// - host opens cycle with frame and 0000
// - host sends read cycle type, 8-bit size
// - channel nibble acts as acknowledge
// - channel nibble top bit marks last byte
// - host sends two data nibbles, low first
// - host turnaround: 1111 then released
// - sync 1001 asks for more bytes
// - sync 0000 ends the transfer
// - three 0101 wait syncs precede final sync
// - peripheral turnaround: 1111 then release
// - channel state kept across foreign cycles
// - channels 5 to 7 use same request format
// - request held off eight clocks after 0000
`timescale 1ns/1ps
module ldrp_periph
    import ldrp_pkg::*;
#(
    parameter int DEPTH = 2
) (
    input  wire logic       clock_i,
    input  wire logic       rst_n_i,
    ldrp_if.dev             link,
    input  wire logic       want_i,
    input  wire logic [2:0] chan_i,
    output logic            busy_o,
    output logic [7:0]      data_o,
    output logic            data_last_o,
    output logic            data_valid_o,
    input  wire logic       data_ready_i
);
    if (DEPTH != 2) begin : g_depth_check
        $error("ldrp_periph: buffer depth must be 2");
    end

    typedef enum {ST_IDLE, ST_CYC, ST_CHAN, ST_SIZE, ST_D0, ST_D1, ST_TAR0, ST_TAR1,
                  ST_WAIT, ST_SYNC, ST_PTAR0, ST_PTAR1} ldrp_bus_t;
    typedef enum {RQ_IDLE, RQ_START, RQ_CH2, RQ_CH1, RQ_CH0, RQ_ACT, RQ_DEASSERT,
                  RQ_PEND, RQ_HOLD} ldrp_req_t;

    typedef struct packed {
        ldrp_req_t  rq;
        ldrp_bus_t  bus;
        logic       req_n;
        logic [2:0] chan;
        logic [3:0] hold;
        logic [3:0] wait_cnt;
        logic [3:0] lo_nib;
        logic       mine;
        logic       tc;
        logic [7:0] byte_v;
        logic [1:0] count;
        logic [8:0] buf0;
        logic [8:0] buf1;
        logic [3:0] ad_out;
        logic       ad_oe;
    } ldrp_state_t;

    ldrp_state_t s;
    ldrp_state_t next_s;
    logic        push;
    logic        pop;
    logic        room;

    assign room         = (s.count < 2'(DEPTH));
    assign data_valid_o = (s.count != 2'h0);
    assign pop          = data_valid_o && data_ready_i;
    assign data_o       = s.buf0[7:0];
    assign data_last_o  = s.buf0[8];
    assign busy_o       = (s.rq != RQ_IDLE);
    assign link.req_n   = s.req_n;
    assign link.dev_ad  = s.ad_out;
    assign link.dev_ad_oe = s.ad_oe;

    always_comb begin
        next_s = s;
        push   = 1'b0;
        // serial request shifter
        case (s.rq)
            RQ_IDLE: begin
                next_s.req_n = 1'b1;
                if (want_i) begin
                    next_s.chan  = chan_i;
                    next_s.req_n = 1'b0;
                    next_s.rq    = RQ_START;
                end
            end
            RQ_START: begin
                next_s.req_n = s.chan[2];
                next_s.rq    = RQ_CH2;
            end
            RQ_CH2: begin
                next_s.req_n = s.chan[1];
                next_s.rq    = RQ_CH1;
            end
            RQ_CH1: begin
                next_s.req_n = s.chan[0];
                next_s.rq    = RQ_CH0;
            end
            RQ_CH0: begin
                next_s.req_n = 1'b1;
                next_s.rq    = RQ_ACT;
            end
            RQ_ACT: begin
                next_s.req_n = 1'b1;
                next_s.rq    = RQ_DEASSERT;
            end
            RQ_DEASSERT: begin
                next_s.rq = RQ_PEND;
            end
            RQ_PEND: begin
                // pend until this channel ends with sync 0000
            end
            RQ_HOLD: begin
                next_s.hold = s.hold - 4'h1;
                if (s.hold == 4'h1) begin
                    next_s.rq = RQ_IDLE;
                end
            end
            default: next_s.rq = RQ_IDLE;
        endcase

        // lpc frame decoder
        next_s.ad_oe = 1'b0;
        case (s.bus)
            ST_IDLE: ;
            ST_CYC: begin
                // low bit of the cycle nibble is don't-care for a read
                if (link.ad[3:2] == LDRP_CYC_DMA && link.ad[1] == LDRP_DIR_READ[1]) begin
                    next_s.bus = ST_CHAN;
                end else begin
                    next_s.bus = ST_IDLE;
                end
            end
            ST_CHAN: begin
                next_s.mine = (s.rq == RQ_PEND) && (link.ad[2:0] == s.chan);
                next_s.tc   = link.ad[LDRP_TC_BIT];
                next_s.bus  = ST_SIZE;
            end
            ST_SIZE: begin
                next_s.bus = (link.ad[1:0] == LDRP_SIZE_8) ? ST_D0 : ST_IDLE;
                if (link.ad[1:0] != LDRP_SIZE_8) next_s.mine = 1'b0;
            end
            ST_D0: begin
                next_s.lo_nib = link.ad;
                next_s.bus    = ST_D1;
            end
            ST_D1: begin
                next_s.byte_v = {link.ad, s.lo_nib};
                next_s.bus    = ST_TAR0;
            end
            ST_TAR0: next_s.bus = ST_TAR1;
            ST_TAR1: begin
                next_s.bus = s.mine ? ST_WAIT : ST_IDLE;
                if (s.mine) begin
                    next_s.wait_cnt = 4'h0;
                    next_s.ad_out   = LDRP_SYNC_WAIT;
                    next_s.ad_oe    = 1'b1;
                end
            end
            ST_WAIT: begin
                next_s.ad_oe = 1'b1;
                next_s.ad_out = LDRP_SYNC_WAIT;
                if (s.wait_cnt == 4'(LDRP_WAIT_NUM - 1) && room) begin
                    // stalls in wait syncs while the buffer is full
                    next_s.ad_out = s.tc ? LDRP_SYNC_DONE : LDRP_SYNC_MORE;
                    next_s.bus    = ST_SYNC;
                    push          = 1'b1;
                end else if (s.wait_cnt != 4'(LDRP_WAIT_NUM - 1)) begin
                    next_s.wait_cnt = s.wait_cnt + 4'h1;
                end
            end
            ST_SYNC: begin
                next_s.ad_out = LDRP_TAR_HIGH;
                next_s.ad_oe  = 1'b1;
                next_s.bus    = ST_PTAR0;
                if (s.tc) begin
                    next_s.rq   = RQ_HOLD;
                    next_s.hold = 4'(LDRP_HOLDOFF);
                end
            end
            ST_PTAR0: next_s.bus = ST_PTAR1;
            ST_PTAR1: next_s.bus = ST_IDLE;
            default:  next_s.bus = ST_IDLE;
        endcase
        // frame with start nibble restarts the decoder anywhere
        if (!link.frame_n) begin
            next_s.bus   = (link.ad == LDRP_START) ? ST_CYC : ST_IDLE;
            next_s.ad_oe = 1'b0;
        end

        // two-entry output buffer
        case ({push, pop})
            2'b10: begin
                if (s.count == 2'h0) next_s.buf0 = {s.tc, s.byte_v};
                else next_s.buf1 = {s.tc, s.byte_v};
                next_s.count = s.count + 2'h1;
            end
            2'b01: begin
                next_s.buf0  = s.buf1;
                next_s.count = s.count - 2'h1;
            end
            2'b11: begin
                if (s.count == 2'h1) next_s.buf0 = {s.tc, s.byte_v};
                else begin
                    next_s.buf0 = s.buf1;
                    next_s.buf1 = {s.tc, s.byte_v};
                end
            end
            default: ;
        endcase
    end

    always_ff @(posedge clock_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            s       <= '0;
            s.rq    <= RQ_IDLE;
            s.bus   <= ST_IDLE;
            s.req_n <= 1'b1;
            s.ad_out <= LDRP_TAR_HIGH;
        end else begin
            s <= next_s;
        end
    end
endmodule : ldrp_periph

// ---- hdl/ldrp_host.sv ----
// host end: decodes serial requests and runs 8-bit dma read cycles
// assumes one lpc clock; bytes supplied by the user, tc chosen by user
`timescale 1ns/1ps
module ldrp_host
    import ldrp_pkg::*;
(
    input  wire logic       clock_i,
    input  wire logic       rst_n_i,
    ldrp_if.host            link,
    input  wire logic       go_i,
    input  wire logic [7:0] byte_i,
    input  wire logic       last_i,
    output logic            go_ready_o,
    output logic            req_seen_o,
    output logic [2:0]      req_chan_o,
    output logic            done_o,
    output logic [3:0]      sync_o
);
    typedef enum {H_IDLE, H_START, H_CYC, H_CHAN, H_SIZE, H_D0, H_D1, H_TAR0, H_TAR1, H_SYNC} ldrp_hstate_t;
    typedef enum {Q_IDLE, Q_B2, Q_B1, Q_B0, Q_ACT} ldrp_qstate_t;

    typedef struct packed {
        ldrp_hstate_t st;
        ldrp_qstate_t q;
        logic [2:0]   qch;
        logic [2:0]   chan;
        logic         seen;
        logic [7:0]   byte_v;
        logic         last;
        logic [4:0]   tmo;
        logic         frame_n;
        logic [3:0]   ad_out;
        logic         ad_oe;
        logic         done;
        logic [3:0]   sync;
    } ldrp_hstate_all_t;

    ldrp_hstate_all_t s;
    ldrp_hstate_all_t next_s;

    assign go_ready_o      = (s.st == H_IDLE) && s.seen;
    assign req_seen_o      = s.seen;
    assign req_chan_o      = s.chan;
    assign done_o          = s.done;
    assign sync_o          = s.sync;
    assign link.frame_n    = s.frame_n;
    assign link.host_ad    = s.ad_out;
    assign link.host_ad_oe = s.ad_oe;

    always_comb begin
        next_s         = s;
        next_s.done    = 1'b0;
        next_s.frame_n = 1'b1;
        next_s.ad_oe   = 1'b1;
        case (s.q)
            Q_IDLE: if (!link.req_n) next_s.q = Q_B2;
            Q_B2: begin
                next_s.qch[2] = link.req_n;
                next_s.q      = Q_B1;
            end
            Q_B1: begin
                next_s.qch[1] = link.req_n;
                next_s.q      = Q_B0;
            end
            Q_B0: begin
                next_s.qch[0] = link.req_n;
                next_s.q      = Q_ACT;
            end
            Q_ACT: begin
                if (link.req_n) begin
                    next_s.seen = 1'b1;
                    next_s.chan = s.qch;
                end
                next_s.q = Q_IDLE;
            end
            default: next_s.q = Q_IDLE;
        endcase
        case (s.st)
            H_IDLE: begin
                next_s.ad_out = LDRP_TAR_HIGH;
                if (go_i && s.seen) begin
                    next_s.byte_v  = byte_i;
                    next_s.last    = last_i;
                    next_s.frame_n = 1'b0;
                    next_s.ad_out  = LDRP_START;
                    next_s.st      = H_START;
                end
            end
            H_START: begin
                next_s.ad_out = {LDRP_CYC_DMA, LDRP_DIR_READ};
                next_s.st     = H_CYC;
            end
            H_CYC: begin
                next_s.ad_out = {s.last, s.chan};
                next_s.st     = H_CHAN;
            end
            H_CHAN: begin
                next_s.ad_out = {2'h0, LDRP_SIZE_8};
                next_s.st     = H_SIZE;
            end
            H_SIZE: begin
                next_s.ad_out = s.byte_v[3:0];
                next_s.st     = H_D0;
            end
            H_D0: begin
                next_s.ad_out = s.byte_v[7:4];
                next_s.st     = H_D1;
            end
            H_D1: begin
                next_s.ad_out = LDRP_TAR_HIGH;
                next_s.st     = H_TAR0;
            end
            H_TAR0: begin
                next_s.ad_oe = 1'b0;
                next_s.tmo   = 5'h0;
                next_s.st    = H_TAR1;
            end
            H_TAR1, H_SYNC: begin
                next_s.ad_oe = 1'b0;
                next_s.st    = H_SYNC;
                next_s.tmo   = s.tmo + 5'h1;
                if (s.st == H_SYNC && link.ad != LDRP_SYNC_WAIT) begin
                    next_s.sync = link.ad;
                    next_s.done = 1'b1;
                    next_s.st   = H_IDLE;
                    next_s.ad_oe = 1'b0;
                    if (link.ad == LDRP_SYNC_DONE) next_s.seen = 1'b0;
                end else if (s.tmo == 5'(LDRP_SYNC_LIMIT)) begin
                    // sixteenth wait sync in a row: abandon and report the bus level seen
                    next_s.sync = link.ad;
                    next_s.done = 1'b1;
                    next_s.st   = H_IDLE;
                end
            end
            default: next_s.st = H_IDLE;
        endcase
    end

    always_ff @(posedge clock_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            s         <= '0;
            s.st      <= H_IDLE;
            s.q       <= Q_IDLE;
            s.frame_n <= 1'b1;
            s.ad_out  <= LDRP_TAR_HIGH;
        end else begin
            s <= next_s;
        end
    end
endmodule : ldrp_host

// ---- verification/ldrp_assertions.sv ----
// checker for the lpc dma link between peripheral and host ends
// assumes it sits beside the interface and sees its plain signals
`timescale 1ns/1ps
module ldrp_assertions
    import ldrp_pkg::*;
(
    input  wire logic       clock_i,
    input  wire logic       rst_n_i,
    input  wire logic       req_n,
    input  wire logic       frame_n,
    input  wire logic [3:0] host_ad,
    input  wire logic       host_ad_oe,
    input  wire logic [3:0] dev_ad,
    input  wire logic       dev_ad_oe,
    input  wire logic [3:0] ad
);
    logic [2:0] rq_pos;
    logic [1:0] fpos;
    logic       tc_q;
    logic       fin;
    logic       wt;
    logic       fstart;
    assign fin    = dev_ad_oe && (dev_ad == LDRP_SYNC_DONE || dev_ad == LDRP_SYNC_MORE);
    assign wt     = dev_ad_oe && dev_ad == LDRP_SYNC_WAIT;
    assign fstart = !frame_n && ad == LDRP_START;
    // position inside a serial request, and the last byte flag of the current frame
    always_ff @(posedge clock_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            rq_pos <= 3'h0;
            fpos   <= 2'h0;
            tc_q   <= 1'b0;
        end else begin
            if (rq_pos == 3'h0) rq_pos <= {2'h0, !req_n};
            else if (rq_pos == 3'h5) rq_pos <= 3'h0;
            else rq_pos <= rq_pos + 3'h1;
            if (!frame_n) fpos <= 2'h1;
            else if (fpos == 2'h1 || fpos == 2'h2) fpos <= fpos + 2'h1;
            if (fpos == 2'h2) tc_q <= host_ad[LDRP_TC_BIT];
        end
    end
    default clocking cb @(posedge clock_i); endclocking
    default disable iff (!rst_n_i);
    a_act_deassert: assert property (rq_pos == 3'h4 |-> req_n ##1 req_n)
        else $error("active or deassert bit not high");
    a_chan_legal: assert property (rq_pos == 3'h4 |-> {$past(req_n, 3), $past(req_n, 2), $past(req_n)} != 3'h4)
        else $error("request carries channel four");
    a_hold_off: assert property (dev_ad_oe && dev_ad == LDRP_SYNC_DONE |=> req_n [*8])
        else $error("request line low too soon after final sync");
    a_wait_before: assert property (fin |-> $past(wt) && $past(wt, 2) && $past(wt, 3))
        else $error("final sync without three wait syncs");
    a_sync_tc: assert property (fin |-> dev_ad == (tc_q ? LDRP_SYNC_DONE : LDRP_SYNC_MORE))
        else $error("final sync code does not match last byte flag");
    a_periph_tar: assert property (fin |=> dev_ad_oe && dev_ad == LDRP_TAR_HIGH ##1 !dev_ad_oe)
        else $error("peripheral turnaround wrong");
    a_host_fields: assert property (fstart |=> host_ad == {LDRP_CYC_DMA, LDRP_DIR_READ} ##2 host_ad[1:0] == LDRP_SIZE_8)
        else $error("host cycle type or size wrong");
    a_host_tar: assert property (fstart |-> ##6 host_ad_oe && host_ad == LDRP_TAR_HIGH ##1 !host_ad_oe)
        else $error("host turnaround wrong");
    a_frame_start: assert property (!frame_n |-> host_ad_oe && host_ad == LDRP_START)
        else $error("frame without start nibble");
    a_one_driver: assert property (!(host_ad_oe && dev_ad_oe))
        else $error("both ends drive the nibble bus");
    cover property (fin && dev_ad == LDRP_SYNC_DONE);
    cover property (fin && dev_ad == LDRP_SYNC_MORE);
    cover property (wt [*4]);
    cover property (rq_pos == 3'h4);
endmodule : ldrp_assertions

// ---- verification/tb.sv ----
// self-checking bench: peripheral and host ends joined through the link
// assumes ldrp_pkg, ldrp_if and both ends compiled first
`timescale 1ns/1ps
module tb;
    import ldrp_pkg::*;
    logic       clock_i      = 1'b0;
    logic       rst_n_i      = 1'b0;
    logic       want_i       = 1'b0;
    logic [2:0] chan_i       = 3'h0;
    logic       data_ready_i = 1'b0;
    logic       go_i         = 1'b0;
    logic [7:0] byte_i       = 8'h00;
    logic       last_i       = 1'b0;
    logic       rdy_en       = 1'b1;
    logic       busy_o, data_last_o, data_valid_o, go_ready_o, req_seen_o, done_o;
    logic [7:0] data_o;
    logic [2:0] req_chan_o;
    logic [3:0] sync_o;
    int         n_errors     = 0;
    int         cmp_count    = 0;
    int         n_done       = 0;
    logic [8:0] exp_q[$];
    ldrp_if link_if ();
    always #2 clock_i = ~clock_i;
    // pull-up when neither end drives
    assign link_if.ad = link_if.dev_ad_oe ? link_if.dev_ad : link_if.host_ad_oe ? link_if.host_ad : 4'hf;
    ldrp_periph #(.DEPTH(2)) ldrp_periph_inst (.clock_i(clock_i), .rst_n_i(rst_n_i), .link(link_if),
        .want_i(want_i), .chan_i(chan_i), .busy_o(busy_o), .data_o(data_o), .data_last_o(data_last_o),
        .data_valid_o(data_valid_o), .data_ready_i(data_ready_i));
    ldrp_host ldrp_host_inst (.clock_i(clock_i), .rst_n_i(rst_n_i), .link(link_if), .go_i(go_i),
        .byte_i(byte_i), .last_i(last_i), .go_ready_o(go_ready_o), .req_seen_o(req_seen_o),
        .req_chan_o(req_chan_o), .done_o(done_o), .sync_o(sync_o));
    ldrp_assertions ldrp_assertions_inst (.clock_i(clock_i), .rst_n_i(rst_n_i), .req_n(link_if.req_n),
        .frame_n(link_if.frame_n), .host_ad(link_if.host_ad), .host_ad_oe(link_if.host_ad_oe),
        .dev_ad(link_if.dev_ad), .dev_ad_oe(link_if.dev_ad_oe), .ad(link_if.ad));
    task automatic check(input logic [31:0] seen, input logic [31:0] exp, input string what);
        cmp_count++;
        if (seen !== exp) begin
            n_errors++;
            $display("mismatch %s expected %0h seen %0h", what, exp, seen);
        end
    endtask : check
    task automatic conclude();
        $display("comparisons %0d mismatches %0d", cmp_count, n_errors);
        if (n_errors == 0 && cmp_count > 0)
            $display("TB: PASS");
        else
            $display("TB: FAIL");
        $finish;
    endtask : conclude
    task automatic expire(input string what);
        n_errors++;
        $display("mismatch %s expected completion seen timeout", what);
        conclude();
    endtask : expire
    task automatic request(input logic [2:0] ch);
        logic [5:0] bits;
        @(posedge clock_i);
        chan_i <= ch;
        want_i <= 1'b1;
        @(posedge clock_i);
        want_i <= 1'b0;
        for (int i = 5; i >= 0; i--) begin
            @(negedge clock_i);
            bits[i] = link_if.req_n;
        end
        check(bits, {1'b0, ch, 2'b11}, "request bits");
        check(busy_o, 1'b1, "busy while pending");
        repeat (4) @(posedge clock_i);
        check(req_seen_o, 1'b1, "request seen");
        check(req_chan_o, ch, "request channel");
    endtask : request
    task automatic xfer(input logic [7:0] b, input logic last);
        int k;
        @(posedge clock_i);
        go_i   <= 1'b1;
        byte_i <= b;
        last_i <= last;
        k = 0;
        do begin
            @(posedge clock_i);
            k++;
        end while (go_ready_o !== 1'b1 && k < 60);
        if (k >= 60) expire("go");
        go_i <= 1'b0;
        exp_q.push_back({last, b});
        k = 0;
        do begin
            @(negedge clock_i);
            k++;
        end while (done_o !== 1'b1 && k < 80);
        if (k >= 80) expire("done");
        n_done++;
        check(sync_o, last ? LDRP_SYNC_DONE : LDRP_SYNC_MORE, "final sync");
    endtask : xfer
    // random gaps stand in for foreign cycles between bytes of one transfer
    task automatic run(input logic [2:0] ch, input int n);
        int k;
        request(ch);
        for (int i = 1; i <= n; i++) begin
            repeat ($urandom % 5) @(posedge clock_i);
            xfer(8'($urandom), i == n);
        end
        k = 0;
        while (busy_o !== 1'b0 && k < 40) begin
            @(posedge clock_i);
            k++;
        end
        if (k >= 40) expire("idle");
        check(link_if.req_n, 1'b1, "idle request line");
        $display("test channel %0d bytes %0d done", ch, n);
    endtask : run
    always @(posedge clock_i) begin
        data_ready_i <= rdy_en && ($urandom % 4 != 0);
        if (data_valid_o === 1'b1 && data_ready_i === 1'b1) begin
            if (exp_q.size() == 0)
                check(0, 1, "spurious byte");
            else
                check({data_last_o, data_o}, exp_q.pop_front(), "byte");
        end
    end
    initial begin
        void'($urandom(32'h8886));
        repeat (3) @(posedge clock_i);
        rst_n_i <= 1'b1;
        for (int i = 0; i < 7; i++) run(3'(i < 4 ? i : i + 1), 1 + i % 3);
        // receiver stalls: two bytes fill the buffer, the third must wait
        rdy_en <= 1'b0;
        n_done = 0;
        fork
            begin
                int w;
                // release after a visible stall, well before the host gives up on the sync
                w = 0;
                for (int k = 0; k < 400 && w < 5; k++) begin
                    @(posedge clock_i);
                    if (n_done >= 2 && link_if.dev_ad_oe === 1'b1 && link_if.dev_ad === LDRP_SYNC_WAIT) w++;
                end
                check(w, 5, "stall wait syncs");
                check(data_valid_o, 1'b1, "buffer held while stalled");
                rdy_en <= 1'b1;
            end
        join_none
        run(3'h2, 3);
        repeat (30) @(posedge clock_i);
        check(exp_q.size(), 0, "bytes left");
        check(data_valid_o, 1'b0, "buffer drained");
        $display("test stall done");
        conclude();
    end
endmodule : tb
